// >>> core/pcc_consts.svh
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_A_STATUS     8'h00
`define PCC_A_CMD        8'h04
`define PCC_A_CFG        8'h08
`define PCC_A_MASK       8'h0C
`define PCC_A_SETUP      8'h10
`define PCC_A_SID        8'h14
`define PCC_A_QUEUE      8'h18
`define PCC_ST_TA        0
`define PCC_ST_RI        3
`define PCC_CFG_TXEN     5
`define PCC_CFG_CHAIN    6
`define PCC_CFG_SWRST    7
`define PCC_CMD_DIS_TX   4'h1
`define PCC_CMD_DIS_RX   4'h2
`define PCC_CMD_EN_TX    4'h3
`define PCC_CMD_EN_RX    4'h4
`define PCC_CMD_CLR_TX   4'h5
`define PCC_CMD_CLR_RX   4'h6
`define PCC_WAKE_PATTERN 8'hD1
`define PCC_WAKE_ADDR0   11'h000
`define PCC_WAKE_ADDR1   11'h001
`define PCC_RESP_OKAY    2'h0
`define PCC_RESP_SLVERR  2'h2
`define PCC_CLK_NS       4
`define PCC_OSC_NS       50
`define PCC_HWRST_OSC    5
`define PCC_HWRST_CYC    ((`PCC_HWRST_OSC * `PCC_OSC_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`define PCC_IRQ_GAP_NS   200
`define PCC_IRQ_GAP_CYC  ((`PCC_IRQ_GAP_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`endif

// >>> core/pcc_pkg.sv
package pcc_pkg;
   typedef enum logic [1:0] {WK_IDLE, WK_PAT, WK_ID} pcc_wake_e;
   typedef struct packed {logic [1:0] cnt; logic [2:0] pg1; logic [2:0] pg0;} pcc_q_s;
   typedef struct packed {logic flag; logic ack; logic hold_v; logic hold_ack;} pcc_res_s;
   typedef struct packed {logic tx_done; logic tx_acked; logic rx_start; logic rx_done;} pcc_eng_s;
   typedef struct packed {logic we; logic [10:0] addr; logic [7:0] data;} pcc_ram_wr_s;
endpackage : pcc_pkg

// >>> core/pcc_top.sv
// Operation
// (R1) chaining off after reset; config bit enables
// (R2) two transmit, two receive commands pending
// (R3) first transmit clears available and acked flags
// (R4) second transmit stored with its page
// (R5) transmit done sets edge flag, interrupt
// (R6) only clear-transmit command clears edge flag
// (R7) first transmit result kept until cleared
// (R8) interrupt held; minimum inactive gap between
// (R9) acked flag buffered, never interrupts
// (R10) stored transmit runs next, shown after clear
// (R11) transmit mask gates only edge flag
// (R12) reset never sets transmit edge flag
// (R13) cancel transmit drops oldest pending
// (R14) first reception sets receive edge flag
// (R15) only clear-receive clears receive status
// (R16) second page receives, reported after clear
// (R17) receive mask gates only edge flag
// (R18) cancel receive drops oldest unless started
// (R19) software reset held while bit set
// (R20) software reset keeps config and setup
// (R21) reset pin filtered, five oscillator periods
// (R22) any reset disables transmitter, clears state
// (R23) station id write triggers two RAM writes; a write of zero triggers none
// (R24) host writes setup before station id
// (R25) third same-type command ignored
`timescale 1ns/10ps
`default_nettype none
`include "pcc_consts.svh"
module pcc_top #(
   parameter int HWRST_CYC = `PCC_HWRST_CYC
) (
   input  wire logic                 core_clk_in,
   input  wire logic                 rstn_in,
   input  wire logic                 hw_reset_n_pin_in,
   input  wire logic                 s_axi_awvalid_in,
   output logic                      s_axi_awready_out,
   input  wire logic [7:0]           s_axi_awaddr_in,
   input  wire logic                 s_axi_wvalid_in,
   output logic                      s_axi_wready_out,
   input  wire logic [31:0]          s_axi_wdata_in,
   input  wire logic [3:0]           s_axi_wstrb_in,
   output logic                      s_axi_bvalid_out,
   input  wire logic                 s_axi_bready_in,
   output logic [1:0]                s_axi_bresp_out,
   input  wire logic                 s_axi_arvalid_in,
   output logic                      s_axi_arready_out,
   input  wire logic [7:0]           s_axi_araddr_in,
   output logic                      s_axi_rvalid_out,
   input  wire logic                 s_axi_rready_in,
   output logic [31:0]               s_axi_rdata_out,
   output logic [1:0]                s_axi_rresp_out,
   input  wire pcc_pkg::pcc_eng_s    eng_in,
   output logic                      tx_req_out,
   output logic [2:0]                tx_page_out,
   output logic                      rx_en_out,
   output logic [2:0]                rx_page_out,
   output var pcc_pkg::pcc_ram_wr_s  ram_wr_out,
   output logic                      irq_out
);
   localparam logic [5:0] GAP = 6'(`PCC_IRQ_GAP_CYC);

   function automatic logic addr_ok(input logic [7:0] a);
      return (a == `PCC_A_STATUS) || (a == `PCC_A_CMD) || (a == `PCC_A_CFG) || (a == `PCC_A_MASK)
             || (a == `PCC_A_SETUP) || (a == `PCC_A_SID) || (a == `PCC_A_QUEUE);
   endfunction : addr_ok

   // pop shifts the oldest entry out before a push lands behind the survivors
   function automatic pcc_pkg::pcc_q_s q_next(input pcc_pkg::pcc_q_s q, input logic push,
                                              input logic pop, input logic [2:0] pg);
      pcc_pkg::pcc_q_s r;
      r = q;
      if (pop)
      begin
         r.pg0 = q.pg1;
         r.cnt = q.cnt - 2'h1;
      end
      if (push)
      begin
         if (r.cnt == 2'h0)
            r.pg0 = pg;
         else
            r.pg1 = pg;
         r.cnt = r.cnt + 2'h1;
      end
      return r;
   endfunction : q_next

   // visible result plus one held result; a completion in the clear cycle shows at once if nothing is held and gap_ok is set
   function automatic pcc_pkg::pcc_res_s res_next(input pcc_pkg::pcc_res_s s, input logic clr,
                                                  input logic done, input logic acked, input logic gap_ok);
      pcc_pkg::pcc_res_s r;
      r = s;
      if (clr)
         r.flag = 1'b0;
      if (done)
      begin
         if (!r.flag && !r.hold_v && gap_ok)
         begin
            r.flag = 1'b1;
            r.ack  = acked;
         end
         else
         begin
            r.hold_v   = 1'b1;
            r.hold_ack = acked;
         end
      end
      else if (!r.flag && r.hold_v && gap_ok)
      begin
         r.flag   = 1'b1;
         r.ack    = r.hold_ack;
         r.hold_v = 1'b0;
      end
      return r;
   endfunction : res_next

   logic                 aw_v_ff, w_v_ff, w_s_ff, b_v_ff, r_v_ff;
   logic [7:0]           aw_a_ff;
   logic [31:0]          w_d_ff, r_d_ff;
   logic [1:0]           b_r_ff, r_r_ff;
   logic                 pin_s1_ff, pin_s2_ff, pin_s3_ff, hw_rst_ff;
   logic [7:0]           hw_cnt_ff, cfg_ff, mask_ff, setup_ff, sid_ff;
   logic [5:0]           gap_cnt_ff, irq_low_ff;
   logic                 rx_busy_ff;
   pcc_pkg::pcc_q_s      tx_q_ff, rx_q_ff, nxt_tx_q, nxt_rx_q;
   pcc_pkg::pcc_res_s    tx_res_ff, rx_res_ff, nxt_tx_res, nxt_rx_res;
   pcc_pkg::pcc_wake_e   wake_ff, nxt_wake;
   pcc_pkg::pcc_ram_wr_s nxt_ram_wr;

   wire       wr_do      = aw_v_ff & w_v_ff & ~b_v_ff;
   wire       wr_en      = wr_do & w_s_ff;
   wire       rd_fire    = s_axi_arvalid_in & ~r_v_ff;
   wire [3:0] cmd_code   = w_d_ff[3:0];
   wire [2:0] cmd_page   = w_d_ff[6:4];
   wire       cmd_wr     = wr_en & (aw_a_ff == `PCC_A_CMD);
   wire       cmd_dis_tx = cmd_wr & (cmd_code == `PCC_CMD_DIS_TX);
   wire       cmd_dis_rx = cmd_wr & (cmd_code == `PCC_CMD_DIS_RX);
   wire       cmd_en_tx  = cmd_wr & (cmd_code == `PCC_CMD_EN_TX);
   wire       cmd_en_rx  = cmd_wr & (cmd_code == `PCC_CMD_EN_RX);
   wire       cmd_clr_tx = cmd_wr & (cmd_code == `PCC_CMD_CLR_TX);
   wire       cmd_clr_rx = cmd_wr & (cmd_code == `PCC_CMD_CLR_RX);
   wire       pin_low    = ~pin_s2_ff & ~pin_s3_ff;
   wire       pin_high   = pin_s2_ff & pin_s3_ff;
   wire       core_rst   = hw_rst_ff | cfg_ff[`PCC_CFG_SWRST]; // [R19] [R21]
   wire       chain      = cfg_ff[`PCC_CFG_CHAIN]; // [R1]
   wire       ta         = (tx_q_ff.cnt == 2'h0);
   wire       ri         = (rx_q_ff.cnt == 2'h0);
   wire       gap_ok     = ~chain | (gap_cnt_ff == 6'h0); // [R8]
   wire       tx_pop     = (eng_in.tx_done | cmd_dis_tx) & ~ta; // [R13]
   wire       tx_push    = cmd_en_tx & (ta | (tx_q_ff.cnt == 2'h1 & chain)); // [R2] [R4] [R25]
   wire       tx_first   = tx_push & ta; // [R3]
   wire       rx_pop     = ~ri & (eng_in.rx_done | (cmd_dis_rx & ~rx_busy_ff)); // [R18]
   wire       rx_push    = cmd_en_rx & (ri | (rx_q_ff.cnt == 2'h1 & chain)); // [R2] [R25]
   wire       sid_wr_nz  = wr_en & (aw_a_ff == `PCC_A_SID) & (w_d_ff[7:0] != 8'h00) & ~core_rst;
   wire [4:0] status     = {rx_res_ff.flag, ri, tx_res_ff.flag, tx_res_ff.ack, ta};
   wire       irq_ch     = (tx_res_ff.flag & mask_ff[`PCC_ST_TA]) | (rx_res_ff.flag & mask_ff[`PCC_ST_RI]);
   wire       irq_nc     = (ta & mask_ff[`PCC_ST_TA]) | (ri & mask_ff[`PCC_ST_RI]);
   wire [31:0] rd_val    = (s_axi_araddr_in == `PCC_A_STATUS) ? 32'(status) :
                           (s_axi_araddr_in == `PCC_A_CFG)    ? 32'(cfg_ff) :
                           (s_axi_araddr_in == `PCC_A_MASK)   ? 32'(mask_ff) :
                           (s_axi_araddr_in == `PCC_A_SETUP)  ? 32'(setup_ff) :
                           (s_axi_araddr_in == `PCC_A_SID)    ? 32'(sid_ff) :
                           (s_axi_araddr_in == `PCC_A_QUEUE)  ? 32'({rx_busy_ff, rx_q_ff.cnt, tx_q_ff.cnt}) :
                           32'h0000_0000;

   assign s_axi_awready_out = ~aw_v_ff & ~b_v_ff;
   assign s_axi_wready_out  = ~w_v_ff & ~b_v_ff;
   assign s_axi_bvalid_out  = b_v_ff;
   assign s_axi_bresp_out   = b_r_ff;
   assign s_axi_arready_out = ~r_v_ff;
   assign s_axi_rvalid_out  = r_v_ff;
   assign s_axi_rdata_out   = r_d_ff;
   assign s_axi_rresp_out   = r_r_ff;
   // transmit mask gates only the edge flag in chaining mode
   assign irq_out     = chain ? irq_ch : irq_nc; // [R11] [R17] [R9]
   assign tx_req_out  = ~ta & cfg_ff[`PCC_CFG_TXEN] & ~core_rst; // [R22]
   assign tx_page_out = tx_q_ff.pg0; // [R10]
   assign rx_en_out   = ~ri & ~core_rst;
   assign rx_page_out = rx_q_ff.pg0; // [R16]

   always_comb
   begin
      nxt_tx_q   = core_rst ? '0 : q_next(tx_q_ff, tx_push, tx_pop, cmd_page);
      nxt_rx_q   = core_rst ? '0 : q_next(rx_q_ff, rx_push, rx_pop, cmd_page);
      // results reset to zero, so no reset ever raises an edge flag
      nxt_tx_res = core_rst ? '0 : res_next(tx_res_ff, cmd_clr_tx, eng_in.tx_done & ~ta, eng_in.tx_acked, gap_ok); // [R5] [R6] [R7] [R12]
      nxt_rx_res = core_rst ? '0 : res_next(rx_res_ff, cmd_clr_rx, eng_in.rx_done & ~ri, 1'b0, gap_ok); // [R14] [R15]
      if (tx_first && !nxt_tx_res.flag)
         nxt_tx_res.ack = 1'b0; // [R3]
   end

   always_comb
   begin
      nxt_wake   = pcc_pkg::WK_IDLE;
      nxt_ram_wr = '0;
      case (wake_ff)
         pcc_pkg::WK_IDLE:
         begin
            if (sid_wr_nz)
               nxt_wake = pcc_pkg::WK_PAT;
         end
         pcc_pkg::WK_PAT:
         begin
            nxt_wake   = pcc_pkg::WK_ID;
            nxt_ram_wr = '{we: 1'b1, addr: `PCC_WAKE_ADDR0, data: `PCC_WAKE_PATTERN}; // [R23]
         end
         pcc_pkg::WK_ID:
            nxt_ram_wr = '{we: 1'b1, addr: `PCC_WAKE_ADDR1, data: sid_ff}; // [R23]
         default:
            nxt_wake = pcc_pkg::WK_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         {aw_v_ff, w_v_ff, w_s_ff, b_v_ff, r_v_ff} <= '0;
         {aw_a_ff, w_d_ff, r_d_ff, b_r_ff, r_r_ff} <= '0;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_v_ff <= 1'b1;
            aw_a_ff <= s_axi_awaddr_in;
         end
         else if (wr_do)
            aw_v_ff <= 1'b0;
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_v_ff <= 1'b1;
            w_d_ff <= s_axi_wdata_in;
            w_s_ff <= s_axi_wstrb_in[0];
         end
         else if (wr_do)
            w_v_ff <= 1'b0;
         if (wr_do)
         begin
            b_v_ff <= 1'b1;
            b_r_ff <= addr_ok(aw_a_ff) ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
         end
         else if (s_axi_bready_in)
            b_v_ff <= 1'b0;
         if (rd_fire)
         begin
            r_v_ff <= 1'b1;
            r_d_ff <= rd_val;
            r_r_ff <= addr_ok(s_axi_araddr_in) ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
         end
         else if (s_axi_rready_in)
            r_v_ff <= 1'b0;
      end
   end

   // the pin counts only once two synchronised samples agree
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         {pin_s1_ff, pin_s2_ff, pin_s3_ff} <= 3'h7;
         hw_cnt_ff <= 8'h00;
         hw_rst_ff <= 1'b0;
      end
      else
      begin
         {pin_s1_ff, pin_s2_ff, pin_s3_ff} <= {hw_reset_n_pin_in, pin_s1_ff, pin_s2_ff};
         if (pin_high)
         begin
            hw_cnt_ff <= 8'h00;
            hw_rst_ff <= 1'b0;
         end
         else if (pin_low && hw_cnt_ff != 8'(HWRST_CYC - 1))
            hw_cnt_ff <= hw_cnt_ff + 8'h01;
         else if (pin_low)
            hw_rst_ff <= 1'b1; // [R21]
      end
   end

   // config and setup survive a software reset, only the filtered pin and rstn_in clear them
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         {cfg_ff, setup_ff, mask_ff, sid_ff} <= '0;
      end
      else
      begin
         if (hw_rst_ff)
            {cfg_ff, setup_ff} <= '0; // [R20]
         else if (wr_en && aw_a_ff == `PCC_A_CFG)
            cfg_ff <= w_d_ff[7:0];
         else if (wr_en && aw_a_ff == `PCC_A_SETUP)
            setup_ff <= w_d_ff[7:0];
         if (core_rst)
            {mask_ff, sid_ff} <= '0; // [R22]
         else if (wr_en && aw_a_ff == `PCC_A_MASK)
            mask_ff <= w_d_ff[7:0];
         else if (wr_en && aw_a_ff == `PCC_A_SID)
            sid_ff <= w_d_ff[7:0];
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         {tx_q_ff, rx_q_ff, tx_res_ff, rx_res_ff, rx_busy_ff} <= '0;
         gap_cnt_ff <= 6'h00;
         irq_low_ff <= GAP;
         wake_ff    <= pcc_pkg::WK_IDLE;
         ram_wr_out <= '0;
      end
      else
      begin
         tx_q_ff    <= nxt_tx_q;
         rx_q_ff    <= nxt_rx_q;
         tx_res_ff  <= nxt_tx_res;
         rx_res_ff  <= nxt_rx_res;
         rx_busy_ff <= ~core_rst & ~eng_in.rx_done & (rx_busy_ff | (eng_in.rx_start & ~ri));
         // reloaded while the line is active, so a new edge waits out the gap after it drops
         gap_cnt_ff <= irq_out ? GAP : gap_cnt_ff - 6'(gap_cnt_ff != 6'h00); // [R8]
         irq_low_ff <= irq_out ? 6'h00 : irq_low_ff + 6'(irq_low_ff != GAP);
         wake_ff    <= nxt_wake;
         ram_wr_out <= nxt_ram_wr;
      end
   end

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_sid_write;
      sid_wr_nz && wake_ff == pcc_pkg::WK_IDLE;
   endsequence
   sequence s_ram_pair;
      ram_wr_out.we && ram_wr_out.addr == `PCC_WAKE_ADDR0 && ram_wr_out.data == `PCC_WAKE_PATTERN ##1
      ram_wr_out.we && ram_wr_out.addr == `PCC_WAKE_ADDR1 && ram_wr_out.data == sid_ff;
   endsequence

   AST_TX_FIRST: assert property (cmd_en_tx && ta && !core_rst |=> tx_q_ff.cnt == 2'h1 && tx_page_out == $past(cmd_page) && !ta) // [R3]
      else $error("first transmit not taken");
   AST_TX_SECOND: assert property (cmd_en_tx && chain && tx_q_ff.cnt == 2'h1 && !tx_pop && !core_rst
                                   |=> tx_q_ff.cnt == 2'h2 && tx_q_ff.pg1 == $past(cmd_page)) // [R4]
      else $error("second transmit not stored");
   AST_TTA_SET: assert property (eng_in.tx_done && !ta && !tx_res_ff.flag && !tx_res_ff.hold_v && gap_ok && !core_rst
                                 |=> tx_res_ff.flag && tx_res_ff.ack == $past(eng_in.tx_acked)) // [R5]
      else $error("transmit done flag not set");
   AST_TTA_HOLD: assert property (tx_res_ff.flag && !cmd_clr_tx && !core_rst |=> tx_res_ff.flag) // [R6]
      else $error("transmit flag cleared without clear command");
   AST_RESULT_KEEP: assert property (tx_res_ff.flag && !cmd_clr_tx && eng_in.tx_done && !ta && !core_rst
                                     |=> tx_res_ff.hold_v && $stable(tx_res_ff.ack)) // [R7]
      else $error("first transmit result overwritten");
   AST_IRQ_GAP: assert property (chain && $stable(mask_ff) && $rose(irq_out) |-> $past(irq_low_ff) == GAP) // [R8]
      else $error("interrupt inactive gap too short");
   AST_TX_AUTO: assert property (eng_in.tx_done && tx_q_ff.cnt == 2'h2 && !cmd_en_tx && !core_rst
                                 |=> tx_q_ff.cnt == 2'h1 && tx_page_out == $past(tx_q_ff.pg1)) // [R10]
      else $error("stored transmit not advanced");
   AST_TX_CANCEL: assert property (cmd_dis_tx && !eng_in.tx_done && tx_q_ff.cnt == 2'h2 && !core_rst
                                   |=> tx_q_ff.cnt == 2'h1 && tx_q_ff.pg0 == $past(tx_q_ff.pg1)) // [R13]
      else $error("cancel did not drop oldest transmit");
   AST_RX_CANCEL: assert property (cmd_dis_rx && rx_busy_ff && !eng_in.rx_done && !cmd_en_rx && !core_rst
                                   |=> $stable(rx_q_ff)) // [R18]
      else $error("started reception cancelled");
   AST_Q_FULL: assert property (cmd_en_tx && tx_q_ff.cnt == 2'h2 && !tx_pop && !core_rst |=> $stable(tx_q_ff)) // [R25]
      else $error("third transmit changed queue");
   AST_WAKE: assert property (s_sid_write |-> ##2 s_ram_pair) // [R23]
      else $error("wake writes missing");
   AST_SWRST: assert property (cfg_ff[`PCC_CFG_SWRST] && !hw_rst_ff |=> tx_q_ff.cnt == 2'h0 && !tx_req_out
                               && $stable(setup_ff)) // [R19] [R20] [R22]
      else $error("software reset not held");
endmodule : pcc_top
`default_nettype wire

// >>> verification/pcc_eng_model.sv
`timescale 1ns/10ps
`default_nettype none
// stands in for the token engine: finishes receptions only while enabled, a transmit on its request or after 200 cycles without one
module pcc_eng_model (
   input  wire logic               clk_in,
   input  wire logic               tx_req_in,
   input  wire logic               rx_en_in,
   output var pcc_pkg::pcc_eng_s   eng_out
);
   initial eng_out = '0;
   // a transmit completes once the request is up, or after 200 cycles without one
   task automatic tx_finish(input logic ack);
      int n;
      n = 0;
      while (tx_req_in !== 1'b1 && n < 200)
      begin
         @(posedge clk_in);
         n++;
      end
      @(posedge clk_in);
      eng_out <= '{tx_done: 1'b1, tx_acked: ack, rx_start: 1'b0, rx_done: 1'b0};
      @(posedge clk_in);
      eng_out <= '0;
   endtask : tx_finish
   // a reception begins and ends only while a receive page is enabled
   task automatic rx_pulse(input logic st, input logic dn);
      @(posedge clk_in);
      eng_out <= '{tx_done: 1'b0, tx_acked: 1'b0, rx_start: st & rx_en_in, rx_done: dn & rx_en_in};
      @(posedge clk_in);
      eng_out <= '0;
   endtask : rx_pulse
endmodule : pcc_eng_model
`default_nettype wire

// >>> verification/pcc_top_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "pcc_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pcc_top_test;
   logic                 clk = 1'b0;
   logic                 rstn = 1'b0;
   logic                 pin = 1'b1;
   logic                 awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic [7:0]           awa = '0, ara = '0;
   logic [31:0]          wd = '0;
   logic                 awr, wr_rdy, bv, arr, rv, txq, rxe, irq;
   logic [1:0]           br, rr;
   logic [31:0]          rdat;
   logic [2:0]           txp, rxp;
   pcc_pkg::pcc_eng_s    eng;
   pcc_pkg::pcc_ram_wr_s ram;
   logic [18:0]          ramq[$];
   int                   n_fail = 0;
   int                   tests_run = 0;
   always #2 clk = ~clk;
   pcc_top #(.HWRST_CYC(4)) dut (.core_clk_in(clk), .rstn_in(rstn), .hw_reset_n_pin_in(pin),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr_rdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h1), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(brdy), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy), .s_axi_rdata_out(rdat),
      .s_axi_rresp_out(rr), .eng_in(eng), .tx_req_out(txq), .tx_page_out(txp), .rx_en_out(rxe),
      .rx_page_out(rxp), .ram_wr_out(ram), .irq_out(irq));
   pcc_eng_model eng_m (.clk_in(clk), .tx_req_in(txq), .rx_en_in(rxe), .eng_out(eng));
   always @(posedge clk)
      if (ram.we === 1'b1)
         ramq.push_back({ram.addr, ram.data});
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `PCC_RESP_OKAY);
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      brdy <= 1'b1;
      fork
         begin do @(posedge clk); while (awr !== 1'b1); awv <= 1'b0; end
         begin do @(posedge clk); while (wr_rdy !== 1'b1); wv <= 1'b0; end
      join
      while (bv !== 1'b1)
         @(posedge clk);
      `CHK(br, er)
      brdy <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `PCC_RESP_OKAY);
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rrdy <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      `CHK(rdat, e)
      `CHK(rr, er)
      rrdy <= 1'b0;
   endtask : rd
   task automatic cmd(input logic [3:0] c, input logic [2:0] pg);
      wr(`PCC_A_CMD, {25'h0, pg, c});
   endtask : cmd
   // held result must wait out the inactive gap before it shows
   task automatic gap_check(input logic [31:0] st);
      `CHK(irq, 1'b0)
      repeat (40) @(posedge clk);
      `CHK(irq, 1'b0)
      repeat (40) if (irq !== 1'b1) @(posedge clk);
      `CHK(irq, 1'b1)
      rd(`PCC_A_STATUS, st);
   endtask : gap_check
   task automatic close_out;
      if (n_fail == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial
   begin
      #(60000 * `PCC_CLK_NS);
      n_fail++;
      close_out();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd(`PCC_A_STATUS, 32'h0000_0009);
      rd(`PCC_A_CFG, 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000, `PCC_RESP_SLVERR);
      wr(8'h3C, 32'h0000_00FF, `PCC_RESP_SLVERR);
      wr(`PCC_A_SETUP, 32'h0000_005A);
      wr(`PCC_A_CFG, 32'h0000_0060);
      wr(`PCC_A_MASK, 32'h0000_0009);
      cmd(`PCC_CMD_EN_TX, 3'd2);
      cmd(`PCC_CMD_EN_TX, 3'd5);
      cmd(`PCC_CMD_EN_TX, 3'd7);
      rd(`PCC_A_QUEUE, 32'h0000_0002);
      `CHK(txp, 3'd2)
      rd(`PCC_A_STATUS, 32'h0000_0008);
      eng_m.tx_finish(1'b1);
      rd(`PCC_A_STATUS, 32'h0000_000E);
      `CHK(irq, 1'b1)
      `CHK(txp, 3'd5)
      eng_m.tx_finish(1'b0);
      rd(`PCC_A_STATUS, 32'h0000_000F);
      `CHK(irq, 1'b1)
      cmd(`PCC_CMD_CLR_TX, 3'd0);
      gap_check(32'h0000_000D);
      cmd(`PCC_CMD_CLR_TX, 3'd0);
      wr(`PCC_A_MASK, 32'h0000_0008);
      cmd(`PCC_CMD_EN_TX, 3'd1);
      eng_m.tx_finish(1'b1);
      repeat (60) @(posedge clk);
      `CHK(irq, 1'b0)
      rd(`PCC_A_STATUS, 32'h0000_000F);
      cmd(`PCC_CMD_CLR_TX, 3'd0);
      wr(`PCC_A_MASK, 32'h0000_0009);
      cmd(`PCC_CMD_EN_TX, 3'd1);
      cmd(`PCC_CMD_EN_TX, 3'd3);
      cmd(`PCC_CMD_DIS_TX, 3'd0);
      `CHK(txp, 3'd3)
      rd(`PCC_A_QUEUE, 32'h0000_0001);
      cmd(`PCC_CMD_DIS_TX, 3'd0);
      rd(`PCC_A_QUEUE, 32'h0000_0000);
      cmd(`PCC_CMD_EN_RX, 3'd4);
      cmd(`PCC_CMD_EN_RX, 3'd6);
      cmd(`PCC_CMD_EN_RX, 3'd1);
      `CHK(rxp, 3'd4)
      `CHK(rxe, 1'b1)
      eng_m.rx_pulse(1'b1, 1'b0);
      cmd(`PCC_CMD_DIS_RX, 3'd0);
      rd(`PCC_A_QUEUE, 32'h0000_0018);
      eng_m.rx_pulse(1'b0, 1'b1);
      rd(`PCC_A_STATUS, 32'h0000_0011);
      `CHK(irq, 1'b1)
      `CHK(rxp, 3'd6)
      eng_m.rx_pulse(1'b1, 1'b1);
      rd(`PCC_A_STATUS, 32'h0000_0019);
      cmd(`PCC_CMD_CLR_RX, 3'd0);
      gap_check(32'h0000_0019);
      cmd(`PCC_CMD_CLR_RX, 3'd0);
      rd(`PCC_A_STATUS, 32'h0000_0009);
      cmd(`PCC_CMD_EN_RX, 3'd2);
      cmd(`PCC_CMD_DIS_RX, 3'd0);
      rd(`PCC_A_QUEUE, 32'h0000_0000);
      `CHK(rxe, 1'b0)
      cmd(`PCC_CMD_EN_TX, 3'd2);
      wr(`PCC_A_CFG, 32'h0000_00E0);
      `CHK(txq, 1'b0)
      cmd(`PCC_CMD_EN_TX, 3'd4);
      rd(`PCC_A_QUEUE, 32'h0000_0000);
      rd(`PCC_A_CFG, 32'h0000_00E0);
      rd(`PCC_A_SETUP, 32'h0000_005A);
      rd(`PCC_A_MASK, 32'h0000_0000);
      wr(`PCC_A_CFG, 32'h0000_0060);
      wr(`PCC_A_SID, 32'h0000_002A);
      repeat (6) @(posedge clk);
      `CHK(ramq.size(), 2)
      `CHK(ramq[0], {`PCC_WAKE_ADDR0, `PCC_WAKE_PATTERN})
      `CHK(ramq[1], {`PCC_WAKE_ADDR1, 8'h2A})
      // a glitch shorter than the filter must leave state alone
      @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
      pin <= 1'b1;
      repeat (8) @(posedge clk);
      rd(`PCC_A_CFG, 32'h0000_0060);
      pin <= 1'b0;
      repeat (14) @(posedge clk);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd(`PCC_A_CFG, 32'h0000_0000);
      rd(`PCC_A_SETUP, 32'h0000_0000);
      rd(`PCC_A_STATUS, 32'h0000_0009);
      `CHK(irq, 1'b0)
      // plain mode: level flags drive the line, a second enqueue is dropped
      wr(`PCC_A_MASK, 32'h0000_0009);
      `CHK(irq, 1'b1)
      cmd(`PCC_CMD_EN_TX, 3'd3);
      cmd(`PCC_CMD_EN_TX, 3'd5);
      rd(`PCC_A_QUEUE, 32'h0000_0001);
      wr(`PCC_A_CFG, 32'h0000_0040);
      `CHK(irq, 1'b0)
      close_out();
   end
endmodule : pcc_top_test
`default_nettype wire
